// File: inc/fsc_defines.svh
// Constants of the FIFO status calendar block
`ifndef FSC_DEFINES_SVH
`define FSC_DEFINES_SVH
`define FSC_CHAN_W 8
`define FSC_IDX_W 8
`define FSC_STAT_W 2
`define FSC_CAL_DEPTH 256
`define FSC_CAL_RESET 8'h00
`define FSC_STAT_RESET 2'h0
`define FSC_FIFO_DEPTH 4
`define FSC_FIFO_AW 2
`define FSC_SNK_SETTLE 5'h1f
`endif

// File: inc/fsc_pkg.sv
// Types of the FIFO status calendar block
`include "fsc_defines.svh"
package fsc_pkg;
   typedef logic [`FSC_CHAN_W-1:0] fsc_chan_t;
   typedef logic [`FSC_IDX_W-1:0] fsc_idx_t;
   typedef logic [`FSC_STAT_W-1:0] fsc_stat_t;
   typedef struct packed {
      fsc_chan_t chan;
      fsc_stat_t stat;
   } fsc_word_t;
endpackage : fsc_pkg

// File: hdl/fsc_fifo.sv
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module fsc_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 4,
   parameter int AW = 2
) (
   input wire logic i_clk,              // Core clock
   input wire logic i_arst_n,           // Async reset, active low
   input wire logic i_in_valid,         // Write side offers a word
   input wire logic [WIDTH-1:0] i_in_data, // Word to store
   output logic o_in_ready,             // Room for a word
   output logic o_out_valid,            // A word is waiting
   output logic [WIDTH-1:0] o_out_data, // Oldest word
   input wire logic i_out_ready         // Reader takes the word
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   always_comb begin
      o_in_ready = (cnt_q != (AW+1)'(DEPTH));
      o_out_valid = (cnt_q != '0);
      o_out_data = mem_q[rd_q];
      push = i_in_valid && o_in_ready;
      pop = o_out_valid && i_out_ready;
      mem_d = mem_q;
      if (push) begin
         mem_d[wr_q] = i_in_data;
      end
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         mem_q <= mem_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end
endmodule : fsc_fifo
`default_nettype wire

// File: hdl/fsc_top.sv
// FIFO status calendar: table, status memories and status link ends
// Functional notes
// - The last-index input holds the number of calendar entries minus one.
// - Status is sent per channel in table order, repeats sending more often.
// - Sink status written by user logic is sent to the peer in table order.
// - Status from the peer lands in the source memory at the table channel.
// - Every table entry comes up as channel zero after reset.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_defines.svh"
module fsc_top
   import fsc_pkg::*;
(
   input wire logic i_clk,               // Core clock, 40 MHz
   input wire logic i_arst_n,            // Async reset, active low
   input wire logic i_enable,            // Status sending active
   input wire logic i_cal_we,            // Table write strobe
   input wire fsc_idx_t i_cal_addr,      // Table entry index
   input wire fsc_chan_t i_cal_data,     // Channel for that entry
   input wire fsc_idx_t i_cal_last,      // Entries minus one
   input wire logic i_snk_we,            // User writes sink status
   input wire fsc_chan_t i_snk_chan,     // Sink channel written
   input wire fsc_stat_t i_snk_stat,     // Sink status value
   input wire fsc_chan_t i_src_chan,     // Source channel to read
   output var fsc_stat_t o_src_stat,     // Source status, next cycle
   input wire logic i_link_clk,          // Status link clock
   output var fsc_stat_t o_tx_stat,      // Status sent to peer
   output logic o_tx_valid,              // Sent status strobe
   input wire logic i_rx_valid,          // Peer status strobe
   input wire fsc_stat_t i_rx_stat       // Status from peer
);
   fsc_chan_t cal_q [`FSC_CAL_DEPTH];
   fsc_chan_t cal_d [`FSC_CAL_DEPTH];
   fsc_stat_t snk_q [`FSC_CAL_DEPTH];
   fsc_stat_t snk_d [`FSC_CAL_DEPTH];
   fsc_stat_t src_q [`FSC_CAL_DEPTH];
   fsc_stat_t src_d [`FSC_CAL_DEPTH];
   fsc_idx_t tx_idx_q, tx_idx_d, rx_idx_q, rx_idx_d;
   fsc_stat_t src_rd_q, src_rd_d;
   fsc_word_t push_word, fifo_word, hs_q, hs_d;
   logic push_ready, fifo_valid, pop;
   logic hreq_q, hreq_d, busy_q, busy_d, hack_s1_q, hack_s2_q;
   logic rreq_s1_q, rreq_s2_q, rseen_q, rseen_d, rx_take;
   logic cal_wr_q, cal_wr_d;
   logic [4:0] snk_age_q, snk_age_d;
   // Link domain
   logic lrst_s1_q, lrst_n;
   logic lreq_s1_q, lreq_s2_q, lseen_q, lseen_d;
   fsc_stat_t tx_stat_q, tx_stat_d, rx_data_q, rx_data_d;
   logic tx_valid_q, tx_valid_d, rreq_q, rreq_d;
   logic rack_s1_q, rack_s2_q;

   // Sequencer offers the table entry at tx_idx while enabled
   always_comb begin
      push_word.chan = cal_q[tx_idx_q];
      push_word.stat = snk_q[cal_q[tx_idx_q]];
   end

   fsc_fifo #(
      .WIDTH($bits(fsc_word_t)),
      .DEPTH(`FSC_FIFO_DEPTH),
      .AW(`FSC_FIFO_AW)
   ) u_fifo (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_in_valid(i_enable),
      .i_in_data(push_word),
      .o_in_ready(push_ready),
      .o_out_valid(fifo_valid),
      .o_out_data(fifo_word),
      .i_out_ready(!busy_q)
   );

   always_comb begin
      cal_d = cal_q;
      snk_d = snk_q;
      src_d = src_q;
      if (i_cal_we) begin
         cal_d[i_cal_addr] = i_cal_data;
      end
      cal_wr_d = cal_wr_q || i_cal_we;
      if (i_snk_we) begin
         snk_d[i_snk_chan] = i_snk_stat;
      end
      // Cycles since the last sink write, saturating
      if (i_snk_we) begin
         snk_age_d = 5'h00;
      end else if (snk_age_q == `FSC_SNK_SETTLE) begin
         snk_age_d = snk_age_q;
      end else begin
         snk_age_d = snk_age_q + 5'h01;
      end
      tx_idx_d = tx_idx_q;
      if (i_enable && push_ready) begin
         tx_idx_d = (tx_idx_q >= i_cal_last) ? '0 : tx_idx_q + 1'b1;
      end
      pop = fifo_valid && !busy_q;
      hs_d = pop ? fifo_word : hs_q;
      hreq_d = pop ? !hreq_q : hreq_q;
      busy_d = pop || (busy_q && (hack_s2_q != hreq_q));
      rx_take = (rreq_s2_q != rseen_q);
      rseen_d = rreq_s2_q;
      rx_idx_d = rx_idx_q;
      if (rx_take) begin
         src_d[cal_q[rx_idx_q]] = rx_data_q;
         rx_idx_d = (rx_idx_q >= i_cal_last) ? '0 : rx_idx_q + 1'b1;
      end
      src_rd_d = src_q[i_src_chan];
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int i = 0; i < `FSC_CAL_DEPTH; i++) begin
            cal_q[i] <= `FSC_CAL_RESET;
            snk_q[i] <= `FSC_STAT_RESET;
            src_q[i] <= `FSC_STAT_RESET;
         end
         cal_wr_q <= 1'b0;
         snk_age_q <= `FSC_SNK_SETTLE;
         tx_idx_q <= '0;
         rx_idx_q <= '0;
         hs_q <= '0;
         hreq_q <= 1'b0;
         busy_q <= 1'b0;
         hack_s1_q <= 1'b0;
         hack_s2_q <= 1'b0;
         rreq_s1_q <= 1'b0;
         rreq_s2_q <= 1'b0;
         rseen_q <= 1'b0;
         src_rd_q <= `FSC_STAT_RESET;
      end else begin
         cal_q <= cal_d;
         snk_q <= snk_d;
         src_q <= src_d;
         cal_wr_q <= cal_wr_d;
         snk_age_q <= snk_age_d;
         tx_idx_q <= tx_idx_d;
         rx_idx_q <= rx_idx_d;
         hs_q <= hs_d;
         hreq_q <= hreq_d;
         busy_q <= busy_d;
         hack_s1_q <= lseen_q;
         hack_s2_q <= hack_s1_q;
         rreq_s1_q <= rreq_q;
         rreq_s2_q <= rreq_s1_q;
         rseen_q <= rseen_d;
         src_rd_q <= src_rd_d;
      end
   end

   assign o_src_stat = src_rd_q;

   // Link reset: asserted at once, released on the link clock
   always_ff @(posedge i_link_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         lrst_s1_q <= 1'b0;
         lrst_n <= 1'b0;
      end else begin
         lrst_s1_q <= 1'b1;
         lrst_n <= lrst_s1_q;
      end
   end

   // Link end: one status per handshake out, one capture per handshake in
   always_comb begin
      lseen_d = lreq_s2_q;
      tx_valid_d = (lreq_s2_q != lseen_q);
      tx_stat_d = tx_valid_d ? hs_q.stat : tx_stat_q;
      rreq_d = rreq_q;
      rx_data_d = rx_data_q;
      if (i_rx_valid && (rreq_q == rack_s2_q)) begin
         rx_data_d = i_rx_stat;
         rreq_d = !rreq_q;
      end
   end

   always_ff @(posedge i_link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         lreq_s1_q <= 1'b0;
         lreq_s2_q <= 1'b0;
         lseen_q <= 1'b0;
         tx_valid_q <= 1'b0;
         tx_stat_q <= `FSC_STAT_RESET;
         rreq_q <= 1'b0;
         rx_data_q <= `FSC_STAT_RESET;
         rack_s1_q <= 1'b0;
         rack_s2_q <= 1'b0;
      end else begin
         lreq_s1_q <= hreq_q;
         lreq_s2_q <= lreq_s1_q;
         lseen_q <= lseen_d;
         tx_valid_q <= tx_valid_d;
         tx_stat_q <= tx_stat_d;
         rreq_q <= rreq_d;
         rx_data_q <= rx_data_d;
         rack_s1_q <= rseen_q;
         rack_s2_q <= rack_s1_q;
      end
   end

   assign o_tx_stat = tx_stat_q;
   assign o_tx_valid = tx_valid_q;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   seq_wrap_a: assert property (
      (i_enable && push_ready && tx_idx_q >= i_cal_last) |=> tx_idx_q == '0)
      else $error("sequence did not wrap to entry zero");
   seq_step_a: assert property (
      (i_enable && push_ready && tx_idx_q < i_cal_last)
      |=> tx_idx_q == $past(tx_idx_q) + 1'b1)
      else $error("sequence did not step to next entry");
   // Words wait in the FIFO, so compare only once the sink memory is quiet
   tx_status_a: assert property (
      pop && snk_age_q == `FSC_SNK_SETTLE
      |=> hs_q.stat == snk_q[hs_q.chan] || $past(i_snk_we))
      else $error("sent status differs from sink memory");
   rx_write_a: assert property (
      rx_take |=> src_q[$past(cal_q[rx_idx_q])] == $past(rx_data_q))
      else $error("received status not stored at table channel");
   cal_init_a: assert property (
      !cal_wr_q |-> cal_q[tx_idx_q] == `FSC_CAL_RESET)
      else $error("unwritten table entry not channel zero");
   hs_hold_a: assert property (
      busy_q && !$past(pop) |-> $stable(hs_q))
      else $error("handshake word changed while busy");
   tx_pulse_a: assert property (@(posedge i_link_clk) disable iff (!lrst_n)
      tx_valid_q |=> !tx_valid_q ##1 !tx_valid_q)
      else $error("sent status strobe too close");
   rx_once_a: assert property (@(posedge i_link_clk) disable iff (!lrst_n)
      $changed(rreq_q) |=> $stable(rreq_q))
      else $error("peer status captured twice in a row");
endmodule : fsc_top
`default_nettype wire

// File: tb/fsc_peer.sv
// Peer model: logs status sent by the block and sends status back
`timescale 1ns/1ps
`default_nettype none
module fsc_peer
   import fsc_pkg::*;
(
   input wire logic i_link_clk,     // Status link clock
   input wire logic i_tx_valid,     // Status strobe from block
   input wire fsc_stat_t i_tx_stat, // Status from block
   output logic o_rx_valid,         // Status strobe to block
   output var fsc_stat_t o_rx_stat  // Status to block
);
   fsc_stat_t got[$];
   initial begin
      o_rx_valid = 1'b0;
      o_rx_stat = 2'h0;
   end
   always @(posedge i_link_clk) begin
      if (i_tx_valid === 1'b1) begin
         got.push_back(i_tx_stat);
      end
   end
   // One strobe, then the value line shows the inverse of the last value
   task automatic send(input fsc_stat_t s);
      @(posedge i_link_clk);
      o_rx_valid <= 1'b1;
      o_rx_stat <= s;
      @(posedge i_link_clk);
      o_rx_valid <= 1'b0;
      o_rx_stat <= ~s;
   endtask : send
endmodule : fsc_peer
`default_nettype wire

// File: tb/fsc_top_bench.sv
// Self-checking bench of the FIFO status calendar block
`timescale 1ns/1ps
`default_nettype none
module fsc_top_bench
   import fsc_pkg::*;
;
   logic clk, arst_n, en, cal_we, snk_we, link_clk, tx_valid, rx_valid;
   fsc_idx_t cal_addr, cal_last;
   fsc_chan_t cal_data, snk_chan, src_chan;
   fsc_stat_t snk_stat, src_stat, tx_stat, rx_stat;
   int failures = 0;
   int n_tests = 0;
   fsc_chan_t cal_tbl [8] = '{8'h00, 8'h01, 8'h02, 8'h03,
                              8'h00, 8'h01, 8'h02, 8'h04};
   fsc_stat_t snk_tbl [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h2};

   always #12.5 clk = ~clk;
   always #3 link_clk = ~link_clk;

   fsc_top dut (.i_clk(clk), .i_arst_n(arst_n), .i_enable(en),
      .i_cal_we(cal_we), .i_cal_addr(cal_addr), .i_cal_data(cal_data),
      .i_cal_last(cal_last), .i_snk_we(snk_we), .i_snk_chan(snk_chan),
      .i_snk_stat(snk_stat), .i_src_chan(src_chan), .o_src_stat(src_stat),
      .i_link_clk(link_clk), .o_tx_stat(tx_stat), .o_tx_valid(tx_valid),
      .i_rx_valid(rx_valid), .i_rx_stat(rx_stat));
   fsc_peer peer (.i_link_clk(link_clk), .i_tx_valid(tx_valid),
      .i_tx_stat(tx_stat), .o_rx_valid(rx_valid), .o_rx_stat(rx_stat));

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input fsc_stat_t g, input fsc_stat_t e);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   task automatic do_reset();
      @(posedge clk);
      arst_n <= 1'b0;
      en <= 1'b0;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      peer.got.delete();
   endtask : do_reset

   task automatic prog_cal();
      int i;
      for (i = 0; i < 8; i++) begin
         @(posedge clk);
         cal_we <= 1'b1;
         cal_addr <= i[7:0];
         cal_data <= cal_tbl[i];
      end
      @(posedge clk);
      cal_we <= 1'b0;
      cal_last <= 8'h07;
   endtask : prog_cal

   task automatic wait_tx(input int n);
      int k;
      for (k = 0; k < 4000 && peer.got.size() < n; k++) @(posedge clk);
      if (peer.got.size() < n) begin
         failures++;
         tally_and_finish();
      end
   endtask : wait_tx

   task automatic rd_src(input fsc_chan_t c, input fsc_stat_t e);
      @(posedge clk);
      src_chan <= c;
      repeat (2) @(posedge clk);
      #1 chk(src_stat, e);
   endtask : rd_src

   task automatic test_default();
      int i;
      do_reset();
      @(posedge clk);
      snk_we <= 1'b1;
      snk_chan <= 8'h00;
      snk_stat <= 2'h3;
      cal_last <= 8'h00;
      @(posedge clk);
      snk_we <= 1'b0;
      en <= 1'b1;
      wait_tx(5);
      en <= 1'b0;
      for (i = 0; i < 5; i++) chk(peer.got[i], 2'h3);
      peer.send(2'h2);
      repeat (8) @(posedge clk);
      rd_src(8'h00, 2'h2);
      $display("test_default done");
   endtask : test_default

   task automatic test_tx_order();
      int i;
      do_reset();
      prog_cal();
      for (i = 0; i < 5; i++) begin
         @(posedge clk);
         snk_we <= 1'b1;
         snk_chan <= i[7:0];
         snk_stat <= snk_tbl[i];
      end
      @(posedge clk);
      snk_we <= 1'b0;
      en <= 1'b1;
      wait_tx(12);
      en <= 1'b0;
      for (i = 0; i < 12; i++) begin
         chk(peer.got[i], snk_tbl[cal_tbl[i % 8]]);
      end
      $display("test_tx_order done");
   endtask : test_tx_order

   task automatic test_rx_order();
      int i;
      fsc_stat_t v;
      fsc_stat_t exp [5] = '{default: 2'h0};
      do_reset();
      prog_cal();
      for (i = 0; i < 9; i++) begin
         v = fsc_stat_t'(i % 3 + 1);
         exp[cal_tbl[i % 8]] = v;
         peer.send(v);
         repeat (30) @(posedge link_clk);
      end
      for (i = 0; i < 5; i++) rd_src(i[7:0], exp[i]);
      $display("test_rx_order done");
   endtask : test_rx_order

   initial begin
      clk = 1'b0;
      link_clk = 1'b0;
      arst_n = 1'b0;
      {en, cal_we, snk_we} = 3'h0;
      {cal_addr, cal_last, cal_data} = 24'h0;
      {snk_chan, src_chan, snk_stat} = 18'h0;
      test_default();
      test_tx_order();
      test_rx_order();
      tally_and_finish();
   end
endmodule : fsc_top_bench
`default_nettype wire
